// >>> sts_pkg.sv
// Shared constants and types for the stepper sequencer control ends
package sts_pkg;
	localparam int          STS_SEQ_W        = 4;          // Sequencer position width (16 positions)
	localparam logic [3:0]  STS_SEQ_HOME     = 4'h0;       // Home excitation position
	localparam logic [3:0]  STS_SEQ_STEP     = 4'h1;       // One sequence increment
	localparam logic [2:0]  STS_MODE_SLEEP   = 3'h7;       // All mode selects high
	localparam int          STS_CLK_HZ       = 50000000;   // System clock rate
	localparam int          STS_SYNC_DECAY_NS = 100000;    // Clock-derived sync idle time
	localparam int          STS_SYNC_DECAY_CYC = STS_SYNC_DECAY_NS / 20; // Rounded down, 20 ns period
	localparam int          STS_SYNC_CNT_W   = 16;
	localparam int          STS_REF_W        = 8;          // Reference code width
	localparam logic [7:0]  STS_REF_DISABLE  = 8'h8C;      // Code for about 1.75 V of full scale
	localparam int          STS_WAKE_NS      = 20000;      // Host wait after ending sleep
	localparam int          STS_WAKE_CYC     = STS_WAKE_NS / 20;
	localparam int          STS_DIV_W        = 16;
	localparam logic [15:0] STS_ONE16        = 16'h0001;
	localparam logic [15:0] STS_ZERO16       = 16'h0000;
	// Host command register offsets (APB byte addresses)
	localparam logic [7:0]  STS_REG_CTRL     = 8'h00;
	localparam logic [7:0]  STS_REG_DIV      = 8'h04;
	localparam logic [7:0]  STS_REG_STAT     = 8'h08;
	localparam logic [7:0]  STS_REG_STEPS    = 8'h0C;
	// CTRL field positions
	localparam int          STS_C_RUN        = 0;
	localparam int          STS_C_DIR        = 1;
	localparam int          STS_C_RST        = 2;
	localparam int          STS_C_SYNC       = 3;
	localparam int          STS_C_MODE_LO    = 4;
	localparam int          STS_C_REF_LO     = 8;
	typedef enum logic [1:0] {
		STS_H_IDLE = 2'b00,
		STS_H_WAKE = 2'b01,
		STS_H_HIGH = 2'b10,
		STS_H_LOW  = 2'b11
	} sts_hstate_t;
endpackage : sts_pkg

// >>> sts_link_if.sv
// Logic pins between the controller and the stepper driver
interface sts_link_if;
	logic       step_clk;
	logic       seq_reset;
	logic       rotation_direction;
	logic       mode_select_bit_a;
	logic       mode_select_bit_b;
	logic       mode_select_bit_c;
	logic       chop_sync;
	logic [7:0] ref_level;
	logic       step_monitor_output;
	logic       outputs_enabled;
	modport drv (input step_clk, seq_reset, rotation_direction, mode_select_bit_a, mode_select_bit_b,
		mode_select_bit_c, chop_sync, ref_level, output step_monitor_output, outputs_enabled);
	modport ctl (output step_clk, seq_reset, rotation_direction, mode_select_bit_a, mode_select_bit_b,
		mode_select_bit_c, chop_sync, ref_level, input step_monitor_output, outputs_enabled);
endinterface : sts_link_if

// >>> sts_driver.sv
// Driver end: excitation sequencer, sleep paths, sync selection and monitors
//
// Overview of operation
// - Power-on reset puts sequencer at home
// - Reset input returns sequencer to home
// - Unused reset input held low by controller
// - One increment per active step edge
// - Dual-edge variant steps on both edges
// - No edges: excitation state held
// - Sync input high selects synchronous chopping
// - Controller keeps sync off except hold
// - Clock-derived sync: high clock clears, idle sets
// - Controller lets the clock rest low for sync
// - All mode selects high: mode-pin sleep
// - High reference level: reference-driven sleep
// - Reference sleep keeps sequencer stepping
// - Mode-pin sleep freezes sequencer
// - Controller waits after sleep before stepping
// - Dual-edge: falling edge valid after sleep
// - Controller ties all logic inputs defined
// - Monitor outputs always actively driven
module sts_driver
	import sts_pkg::*;
#(
	parameter bit DUAL_EDGE  = 1'b0,
	parameter bit CLK_SYNC   = 1'b0,
	parameter int DECAY_CYC  = STS_SYNC_DECAY_CYC
)(
	// Clock and power-on reset
	input  wire logic                 mclk_in,
	input  wire logic                 rst_in,
	// Link to controller
	sts_link_if.drv                   link,
	// Driver-side status
	output logic [sts_pkg::STS_SEQ_W-1:0] seq_pos_out,
	output logic [2:0]                step_mode_out,
	output logic                      sync_chop_out,
	output logic                      sleep_out
);
	import sts_pkg::*;

	logic                      clk_d_ff;
	logic [STS_SEQ_W-1:0]      pos_ff;
	logic [2:0]                mode_ff;
	logic                      sync_ff;
	logic                      sleep_ff;
	logic                      mon_ff;
	logic                      en_ff;
	logic [STS_SYNC_CNT_W-1:0] idle_ff;
	logic [STS_SYNC_CNT_W-1:0] nxt_idle;

	//////////////////////////////////////////////////////////////////////////
	// Decode of edges and sleeps
	wire rise_w      = link.step_clk & ~clk_d_ff;
	wire fall_w      = ~link.step_clk & clk_d_ff;
	wire act_edge_w  = rise_w | (DUAL_EDGE & fall_w);
	wire mode_sleep_w = {link.mode_select_bit_c, link.mode_select_bit_b,
		link.mode_select_bit_a} == STS_MODE_SLEEP;
	wire ref_sleep_w = link.ref_level >= STS_REF_DISABLE;
	wire step_w      = act_edge_w & ~mode_sleep_w;
	wire idle_done_w = idle_ff >= STS_SYNC_CNT_W'(DECAY_CYC);
	wire sync_sel_w  = CLK_SYNC ? sync_ff : link.chop_sync;

	// Idle counter models the RC decay; high clock recharges it
	always_comb
	begin
		if (link.step_clk)
			nxt_idle = STS_ZERO16;
		else if (idle_done_w)
			nxt_idle = idle_ff;
		else
			nxt_idle = idle_ff + STS_ONE16;
	end

	//////////////////////////////////////////////////////////////////////////
	// Sequencer position: reset, step, hold
	always_ff @(posedge mclk_in)
	begin
		if (rst_in || link.seq_reset)
			pos_ff <= STS_SEQ_HOME;
		else if (step_w)
			pos_ff <= link.rotation_direction ? pos_ff + STS_SEQ_STEP
				: pos_ff - STS_SEQ_STEP;
		// No edge leaves the position untouched
	end

	// Edge history, sync, sleep and monitors
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			clk_d_ff <= 1'b0;
			idle_ff  <= STS_ZERO16;
			sync_ff  <= 1'b0;
			sleep_ff <= 1'b0;
			mon_ff   <= 1'b1;                           // Home shows at once
			en_ff    <= 1'b0;
			mode_ff  <= 3'h0;
		end
		else
		begin
			clk_d_ff <= link.step_clk;
			idle_ff  <= nxt_idle;
			sync_ff  <= ~link.step_clk & idle_done_w;
			sleep_ff <= mode_sleep_w | ref_sleep_w;
			en_ff    <= ~(mode_sleep_w | ref_sleep_w);
			mon_ff   <= (pos_ff == STS_SEQ_HOME);
			mode_ff  <= {link.mode_select_bit_c, link.mode_select_bit_b, link.mode_select_bit_a};
		end
	end

	// Monitors always driven, never floating        
	assign link.step_monitor_output = mon_ff;
	assign link.outputs_enabled     = en_ff;
	assign seq_pos_out   = pos_ff;
	assign step_mode_out = mode_ff;
	assign sleep_out     = sleep_ff;

	// Chop mode registered so the output stays clean
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
			sync_chop_out <= 1'b0;
		else
			sync_chop_out <= sync_sel_w;
	end
endmodule : sts_driver

// >>> sts_ctrl.sv
// Controller end: APB command registers driving the stepper logic pins
//
// Local design decisions: the register offsets and the APB register port.
module sts_ctrl
	import sts_pkg::*;
#(
	parameter int WAKE_CYC = STS_WAKE_CYC
)(
	// Clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Link to driver
	sts_link_if.ctl          link
);
	import sts_pkg::*;

	logic [11:0]          ctrl_ff;
	logic [STS_DIV_W-1:0] div_ff;
	logic [STS_DIV_W-1:0] cnt_ff;
	logic [15:0]          steps_ff;
	logic [15:0]          wake_ff;
	logic                 clk_ff;
	logic                 was_sleep_ff;
	sts_hstate_t          st_ff;

	//////////////////////////////////////////////////////////////////////////
	// APB decode; slave answers in the access cycle
	wire acc_w    = psel & penable;
	wire wr_w     = acc_w & pwrite;
	wire hit_w    = paddr == STS_REG_CTRL || paddr == STS_REG_DIV || paddr == STS_REG_STAT
		|| paddr == STS_REG_STEPS;
	// Reference code from the top CTRL nibble with low nibble zero; both ends compare this code for sleep
	wire [7:0] ref_code_w = {ctrl_ff[STS_C_REF_LO +: 4], 4'h0};
	wire sleep_w  = ctrl_ff[STS_C_MODE_LO +: 3] == STS_MODE_SLEEP
		|| ref_code_w >= STS_REF_DISABLE;
	wire tick_w   = cnt_ff >= div_ff;
	// Sleep just ended: no clock edge of any kind until the wake delay is over
	wire wake_w   = was_sleep_ff & ~sleep_w;
	wire waking_w = wake_ff != STS_ZERO16;
	wire pace_w   = tick_w & ~wake_w & ~waking_w;
	// Steps may go on in sleep; the driver decides whether they count
	wire go_w     = ctrl_ff[STS_C_RUN] & ~ctrl_ff[STS_C_RST];

	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			ctrl_ff <= 12'h000;
			div_ff  <= 16'h00FF;
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit_w;
			if (psel & ~penable)
				prdata <= paddr == STS_REG_CTRL ? {20'h00000, ctrl_ff}
					: paddr == STS_REG_DIV ? {16'h0000, div_ff}
					: paddr == STS_REG_STAT ? {28'h0000000, link.outputs_enabled,
						link.step_monitor_output, waking_w, sleep_w}
					: paddr == STS_REG_STEPS ? {16'h0000, steps_ff} : 32'h00000000;
			if (wr_w && pready && paddr == STS_REG_CTRL)
				ctrl_ff <= pwdata[11:0];
			if (wr_w && pready && paddr == STS_REG_DIV)
				div_ff <= pwdata[15:0];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Step clock generator with post-sleep wake delay
	always_ff @(posedge mclk_in)
	begin
		if (rst_in)
		begin
			st_ff        <= STS_H_IDLE;
			cnt_ff       <= STS_ZERO16;
			clk_ff       <= 1'b0;
			wake_ff      <= STS_ZERO16;
			steps_ff     <= STS_ZERO16;
			was_sleep_ff <= 1'b0;
		end
		else
		begin
			was_sleep_ff <= sleep_w;
			cnt_ff <= tick_w ? STS_ZERO16 : cnt_ff + STS_ONE16;
			// Wake delay runs in any state, as the clock may be mid-pulse
			if (wake_w)
				wake_ff <= 16'(WAKE_CYC);
			else if (waking_w)
				wake_ff <= wake_ff - STS_ONE16;
			case (st_ff)
				STS_H_IDLE:
					if (wake_w)
						st_ff <= STS_H_WAKE;
					else if (go_w && pace_w)
						st_ff <= STS_H_HIGH;
				STS_H_WAKE:
					if (!waking_w)
						st_ff <= STS_H_IDLE;
				STS_H_HIGH:
					if (pace_w)
					begin
						clk_ff   <= 1'b1;
						steps_ff <= steps_ff + STS_ONE16;
						st_ff    <= STS_H_LOW;
					end
				STS_H_LOW:
					if (pace_w)
					begin
						clk_ff <= 1'b0;                     // Clock rests low for sync
						st_ff  <= STS_H_IDLE;
					end
				default:
					st_ff <= STS_H_IDLE;
			endcase
		end
	end

	// Pins driven from registers, chop_sync gated by RUN, and all always defined
	assign link.step_clk           = clk_ff;
	assign link.seq_reset          = ctrl_ff[STS_C_RST];
	assign link.rotation_direction = ctrl_ff[STS_C_DIR];
	assign link.chop_sync          = ctrl_ff[STS_C_SYNC] & ~ctrl_ff[STS_C_RUN];
	assign link.mode_select_bit_a  = ctrl_ff[STS_C_MODE_LO];
	assign link.mode_select_bit_b  = ctrl_ff[STS_C_MODE_LO + 1];
	assign link.mode_select_bit_c  = ctrl_ff[STS_C_MODE_LO + 2];
	assign link.ref_level          = ref_code_w;
endmodule : sts_ctrl

// >>> sts_link_asserts.sv
// Checker on the link between the controller and driver ends
module sts_link_asserts
(
	// Clock and reset
	input wire logic       mclk_in,
	input wire logic       rst_in,
	// Link signals
	input wire logic       step_clk,
	input wire logic       seq_reset,
	input wire logic       mode_select_bit_a,
	input wire logic       mode_select_bit_b,
	input wire logic       mode_select_bit_c,
	input wire logic [7:0] ref_level,
	input wire logic       step_monitor_output,
	input wire logic       outputs_enabled
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// Decoded sleep requests
	wire mode_slp = mode_select_bit_a & mode_select_bit_b & mode_select_bit_c;
	wire ref_slp  = (ref_level >= 8'h8C);
	// A step shows on the monitor two cycles after the edge is sampled
	sequence s_fall_free;
		$fell(step_clk) && !seq_reset;
	endsequence
	sequence s_mon_still;
		$stable(step_monitor_output);
	endsequence
	a_mode_sleep: assert property (mode_slp[*3] |-> !outputs_enabled)
		else $error("outputs on in mode sleep");
	a_ref_sleep: assert property (ref_slp[*3] |-> !outputs_enabled)
		else $error("outputs on in reference sleep");
	a_awake_on: assert property ((!mode_slp && !ref_slp)[*3] |-> outputs_enabled)
		else $error("outputs off while awake");
	a_reset_home: assert property (seq_reset[*4] |-> step_monitor_output)
		else $error("not home under reset");
	a_hold_still: assert property ((!seq_reset && $stable(step_clk))[*6] |-> $stable(step_monitor_output))
		else $error("position moved without edge");
	a_freeze_sleep: assert property ((mode_slp && !seq_reset)[*6] |-> $stable(step_monitor_output))
		else $error("position moved in mode sleep");
	a_step_leaves: assert property ($rose(step_clk) && step_monitor_output && !mode_slp && !seq_reset
		|-> ##[1:5] !step_monitor_output)
		else $error("rising edge did not step");
	a_fall_ignored: assert property (s_fall_free |=> ##1 s_mon_still)
		else $error("falling edge stepped");
endmodule : sts_link_asserts

// >>> tb_top.sv
// Bench joining controller and driver ends over the link
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sts_pkg::*;
	logic        mclk_in = 1'b0;
	logic        rst_in  = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, sync_chop_out, sleep_out;
	logic [3:0]  seq_pos_out;
	logic [3:0]  seq_pos_w;
	logic [2:0]  step_mode_out;
	logic        sync_chop_w;
	logic [32:0] exp_q[$];
	int          num_errors = 0;
	int          checks = 0;
	int          cycles = 0;
	int          rises = 0;
	int          r0, r1;
	event        probe_ev;
	sts_link_if link();
	sts_link_if link_w();
	always #10 mclk_in = ~mclk_in;
	////////////////////////////////////////////////////////////////////////////////
	// Short counts keep the run brief
	sts_driver #(.DUAL_EDGE(1'b0), .CLK_SYNC(1'b0), .DECAY_CYC(8)) sts_driver_inst (.mclk_in(mclk_in),
		.rst_in(rst_in), .link(link), .seq_pos_out(seq_pos_out), .step_mode_out(step_mode_out),
		.sync_chop_out(sync_chop_out), .sleep_out(sleep_out));
	// Dual-edge variant with clock-derived sync listens to the same pins
	sts_driver #(.DUAL_EDGE(1'b1), .CLK_SYNC(1'b1), .DECAY_CYC(8)) sts_driver_w_inst (.mclk_in(mclk_in),
		.rst_in(rst_in), .link(link_w), .seq_pos_out(seq_pos_w), .step_mode_out(),
		.sync_chop_out(sync_chop_w), .sleep_out());
	assign link_w.step_clk           = link.step_clk;
	assign link_w.seq_reset          = link.seq_reset;
	assign link_w.rotation_direction = link.rotation_direction;
	assign link_w.mode_select_bit_a  = link.mode_select_bit_a;
	assign link_w.mode_select_bit_b  = link.mode_select_bit_b;
	assign link_w.mode_select_bit_c  = link.mode_select_bit_c;
	assign link_w.chop_sync          = link.chop_sync;
	assign link_w.ref_level          = link.ref_level;
	sts_ctrl #(.WAKE_CYC(4)) sts_ctrl_inst (.mclk_in(mclk_in), .rst_in(rst_in), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	sts_link_asserts sts_link_asserts_inst (.mclk_in(mclk_in), .rst_in(rst_in), .step_clk(link.step_clk),
		.seq_reset(link.seq_reset), .mode_select_bit_a(link.mode_select_bit_a),
		.mode_select_bit_b(link.mode_select_bit_b), .mode_select_bit_c(link.mode_select_bit_c),
		.ref_level(link.ref_level), .step_monitor_output(link.step_monitor_output),
		.outputs_enabled(link.outputs_enabled));
	////////////////////////////////////////////////////////////////////////////////
	// Own count of rises on the wire, so expectations never read the design
	always @(posedge link.step_clk) rises <= rises + 1;
	task automatic close_out(input int t);
		num_errors += t;
		if (num_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	task automatic cmp(input logic [32:0] got);
		logic [32:0] e;
		e = exp_q.pop_front();
		checks++;
		if (got !== e)
		begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, e);
		end
	endtask : cmp
	// Watcher: APB read answers and timeout
	always @(posedge mclk_in)
	begin
		cycles <= cycles + 1;
		if (cycles > 40000)
			close_out(1);
		if (psel && penable && pready && !pwrite)
			cmp({pslverr, prdata});
	end
	// Watcher: driver outputs, taken at the falling edge where they are settled
	always @(probe_ev) cmp({19'h0, seq_pos_w, sync_chop_w, step_mode_out, sync_chop_out, sleep_out, seq_pos_out});
	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		do @(posedge mclk_in); while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// Dual-edge position is twice the standard one; idle clock means sync high
	task automatic probe(input logic [2:0] m, input logic s, input logic sl, input logic [3:0] p);
		logic [32:0] e;
		e = {19'h0, p[2:0], 1'b0, 1'b1, m, s, sl, p};
		repeat (30) @(posedge mclk_in);
		@(negedge mclk_in);
		exp_q.push_back(e);
		-> probe_ev;
	endtask : probe
	// Random rate and length of a burst of steps, then stop
	task automatic spin(input logic [31:0] c);
		apb(1'b1, STS_REG_DIV, $urandom_range(3, 1));
		apb(1'b1, STS_REG_CTRL, c | 32'h1);
		repeat ($urandom_range(200, 60)) @(posedge mclk_in);
		apb(1'b1, STS_REG_CTRL, c);
		// A pulse already begun still finishes; let it land before counting
		repeat (30) @(posedge mclk_in);
	endtask : spin
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		void'($urandom(32'hBE8A));
		repeat (16) @(posedge mclk_in);
		rst_in <= 1'b0;
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		rd(STS_REG_CTRL, 33'h0);
		rd(STS_REG_DIV, 33'hFF);
		rd(8'h10, 33'h1_0000_0000);
		probe(3'h0, 1'b0, 1'b0, 4'h0);
		spin(32'h2);
		probe(3'h0, 1'b0, 1'b0, 4'(rises));
		rd(STS_REG_STEPS, 33'(rises));
		r0 = rises;
		spin(32'h0);
		r0 = 2 * r0 - rises;
		probe(3'h0, 1'b0, 1'b0, 4'(r0));
		spin(32'h72);
		probe(3'h7, 1'b0, 1'b1, 4'(r0));
		r1 = rises;
		spin(32'hF02);
		probe(3'h0, 1'b0, 1'b1, 4'(r0 + rises - r1));
		apb(1'b1, STS_REG_CTRL, 32'h4);
		probe(3'h0, 1'b0, 1'b0, 4'h0);
		apb(1'b1, STS_REG_CTRL, 32'h8);
		probe(3'h0, 1'b1, 1'b0, 4'h0);
		apb(1'b1, STS_REG_CTRL, 32'h0);
		probe(3'h0, 1'b0, 1'b0, 4'h0);
		rd(STS_REG_STAT, 33'hC);
		close_out(0);
	end
endmodule : tb_top
